// file: rtl/lesm_regs.svh
// Summary of operation
// - Rising pulse drives its target on for one scan on an off-to-on input change.
// - Falling pulse drives its target on for one scan on an on-to-off input change.
// - Returning from stop to run does not make a fired edge pulse fire again.
// - Bit shift copies the device one below into the target, then clears that lower device.
// - With range condition on, instructions up to the matching close execute normally.
// - With range condition off, every instruction in the range is still stepped through.
// - Range off clears non-retentive timers' value and forces their coil and contact off.
// - Range off turns retentive timer coils off, keeping value and contact.
// - Range off turns output coils off; set, reset and shift targets keep state.
// - Range open energizes its named device coil; author uses it nowhere else as coil.
// - The same nesting level may be opened many times with different control devices.
// - Eight levels N0 to N7; author opens ascending and closes descending.
// - One close at the lowest level ends all enclosed ranges at once.
// - Program end finishes the scan and restarts execution at step 0.
// - A program without an end instruction raises an operation error and does not run; the core first runs every step up to 255, then faults.
// - No-operation leaves logic result and devices untouched but takes one step.
// - A set device stays on after its condition drops, until a reset clears it.
`ifndef LESM_REGS_SVH
`define LESM_REGS_SVH

`define LESM_DEV_W 6
`define LESM_NDEV 64
`define LESM_LVL_W 3
`define LESM_NLVL 8
`define LESM_PC_W 8
`define LESM_NSTEP 256
`define LESM_PC_LAST 8'hFF
`define LESM_PC_RST 8'h00
`define LESM_DEV_RST 64'h0000000000000000
`define LESM_LVL_RST 8'h00

`endif

// file: rtl/lesm_pkg.sv
package lesm_pkg;

    typedef enum logic [3:0] {
        LESM_OP_NOP = 4'h0,
        LESM_OP_OUT = 4'h1,
        LESM_OP_SET = 4'h2,
        LESM_OP_RESET_DEV = 4'h3,
        LESM_OP_RISE_PULSE = 4'h4,
        LESM_OP_FALL_PULSE = 4'h5,
        LESM_OP_BIT_SHIFT = 4'h6,
        LESM_OP_BIT_SHIFT_EDGE = 4'h7,
        LESM_OP_RANGE_OPEN = 4'h8,
        LESM_OP_RANGE_CLOSE = 4'h9,
        LESM_OP_PROG_END = 4'hA,
        LESM_OP_TIMER = 4'hB,
        LESM_OP_TIMER_RET = 4'hC
    } lesm_op_t;

    typedef enum logic [1:0] {
        LESM_ST_IDLE = 2'b00,
        LESM_ST_RUN = 2'b01,
        LESM_ST_FAULT = 2'b10
    } lesm_state_t;

endpackage

// file: rtl/lesm_core.sv
`timescale 1ns/1ps
`include "lesm_regs.svh"

module lesm_core
    import lesm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [3:0] i_op,
    input wire logic i_cond,
    input wire logic [`LESM_LVL_W-1:0] i_level,
    input wire logic [`LESM_DEV_W-1:0] i_dev,
    output logic [`LESM_PC_W-1:0] o_pc,
    output logic [`LESM_NDEV-1:0] o_dev,
    output logic o_tmr_valid,
    output logic [`LESM_DEV_W-1:0] o_tmr_idx,
    output logic o_tmr_coil,
    output logic o_tmr_clr,
    output logic o_scan_end,
    output logic o_running,
    output logic o_op_err
);

    lesm_state_t st_r, st_nxt;
    logic [`LESM_PC_W-1:0] pc_r, pc_nxt;
    logic [`LESM_NDEV-1:0] dev_r, dev_nxt;
    logic [`LESM_NSTEP-1:0] prev_r, prev_nxt;
    logic [`LESM_NLVL-1:0] open_r, open_nxt;
    logic [`LESM_NLVL-1:0] lcond_r, lcond_nxt;
    logic tmr_valid_r, tmr_valid_nxt;
    logic [`LESM_DEV_W-1:0] tmr_idx_r, tmr_idx_nxt;
    logic tmr_coil_r, tmr_coil_nxt;
    logic tmr_clr_r, tmr_clr_nxt;
    logic end_r, end_nxt;
    logic err_r, err_nxt;
    logic running_r, running_nxt;
    logic en;
    logic c;

    // Off-to-on change between last scan's condition and this one
    function automatic logic lesm_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    // Common bus is live only if every open level has its condition on
    function automatic logic lesm_range_en(input logic [`LESM_NLVL-1:0] open,
                                           input logic [`LESM_NLVL-1:0] cond);
        return &(~open | cond);
    endfunction

    // Moves the lower neighbour into the target and clears the neighbour
    function automatic logic [`LESM_NDEV-1:0] lesm_shift(input logic [`LESM_NDEV-1:0] d,
                                                         input logic [`LESM_DEV_W-1:0] idx);
        logic [`LESM_NDEV-1:0] r;
        r = d;
        if (idx == '0) begin
            r[idx] = 1'b0;
        end else begin
            r[idx] = d[idx - 1'b1];
            r[idx - 1'b1] = 1'b0;
        end
        return r;
    endfunction

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        dev_nxt = dev_r;
        prev_nxt = prev_r;
        open_nxt = open_r;
        lcond_nxt = lcond_r;
        tmr_valid_nxt = 1'b0;
        tmr_idx_nxt = tmr_idx_r;
        tmr_coil_nxt = 1'b0;
        tmr_clr_nxt = 1'b0;
        end_nxt = 1'b0;
        err_nxt = err_r;
        en = lesm_range_en(open_r, lcond_r);
        // A disabled range sees every condition as off
        c = i_cond & en;
        case (st_r)
            LESM_ST_IDLE: begin
                // Edge memory is left alone here so a restart cannot re-fire
                pc_nxt = `LESM_PC_RST;
                if (i_run) begin
                    st_nxt = LESM_ST_RUN;
                end
            end
            LESM_ST_RUN: begin
                // One step per clock whether or not the range is live
                pc_nxt = pc_r + 1'b1;
                case (lesm_op_t'(i_op))
                    LESM_OP_OUT: begin
                        dev_nxt[i_dev] = c;
                    end
                    LESM_OP_SET: begin
                        if (c) begin
                            dev_nxt[i_dev] = 1'b1;
                        end
                    end
                    LESM_OP_RESET_DEV: begin
                        if (c) begin
                            dev_nxt[i_dev] = 1'b0;
                        end
                    end
                    LESM_OP_RISE_PULSE: begin
                        dev_nxt[i_dev] = lesm_rise(prev_r[pc_r], c);
                        prev_nxt[pc_r] = c;
                    end
                    LESM_OP_FALL_PULSE: begin
                        // A dead range forces the condition off, which must not read as a falling edge
                        dev_nxt[i_dev] = en & lesm_rise(c, prev_r[pc_r]);
                        prev_nxt[pc_r] = c;
                    end
                    LESM_OP_BIT_SHIFT: begin
                        if (c) begin
                            dev_nxt = lesm_shift(dev_r, i_dev);
                        end
                    end
                    LESM_OP_BIT_SHIFT_EDGE: begin
                        if (lesm_rise(prev_r[pc_r], c)) begin
                            dev_nxt = lesm_shift(dev_r, i_dev);
                        end
                        prev_nxt[pc_r] = c;
                    end
                    LESM_OP_RANGE_OPEN: begin
                        // A reopened level simply takes the new condition
                        open_nxt[i_level] = 1'b1;
                        lcond_nxt[i_level] = c;
                        dev_nxt[i_dev] = c;
                    end
                    LESM_OP_RANGE_CLOSE: begin
                        for (int k = 0; k < `LESM_NLVL; k++) begin
                            if (k >= int'(i_level)) begin
                                open_nxt[k] = 1'b0;
                            end
                        end
                    end
                    LESM_OP_TIMER: begin
                        tmr_valid_nxt = 1'b1;
                        tmr_idx_nxt = i_dev;
                        tmr_coil_nxt = c;
                        tmr_clr_nxt = ~en;
                    end
                    LESM_OP_TIMER_RET: begin
                        // Value and contact are the timer's own; only the coil drops
                        tmr_valid_nxt = 1'b1;
                        tmr_idx_nxt = i_dev;
                        tmr_coil_nxt = c;
                    end
                    LESM_OP_PROG_END: begin
                        pc_nxt = `LESM_PC_RST;
                        end_nxt = 1'b1;
                        open_nxt = `LESM_LVL_RST;
                        if (!i_run) begin
                            st_nxt = LESM_ST_IDLE;
                        end
                    end
                    default: begin
                        // No operation: only the step counter moves
                        dev_nxt = dev_r;
                    end
                endcase
                if (lesm_op_t'(i_op) != LESM_OP_PROG_END && pc_r == `LESM_PC_LAST) begin
                    // Falling off the program store means no end was present
                    err_nxt = 1'b1;
                    st_nxt = LESM_ST_FAULT;
                    pc_nxt = `LESM_PC_RST;
                    dev_nxt = `LESM_DEV_RST;
                end
            end
            LESM_ST_FAULT: begin
                // Held until reset; the program is refused outright
                pc_nxt = `LESM_PC_RST;
            end
            default: begin
                st_nxt = LESM_ST_IDLE;
            end
        endcase
        running_nxt = (st_nxt == LESM_ST_RUN);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= LESM_ST_IDLE;
            pc_r <= `LESM_PC_RST;
            dev_r <= `LESM_DEV_RST;
            prev_r <= '0;
            open_r <= `LESM_LVL_RST;
            lcond_r <= `LESM_LVL_RST;
            tmr_valid_r <= 1'b0;
            tmr_idx_r <= '0;
            tmr_coil_r <= 1'b0;
            tmr_clr_r <= 1'b0;
            end_r <= 1'b0;
            err_r <= 1'b0;
            running_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            dev_r <= dev_nxt;
            prev_r <= prev_nxt;
            open_r <= open_nxt;
            lcond_r <= lcond_nxt;
            tmr_valid_r <= tmr_valid_nxt;
            tmr_idx_r <= tmr_idx_nxt;
            tmr_coil_r <= tmr_coil_nxt;
            tmr_clr_r <= tmr_clr_nxt;
            end_r <= end_nxt;
            err_r <= err_nxt;
            running_r <= running_nxt;
        end
    end

    always_comb begin
        o_pc = pc_r;
        o_dev = dev_r;
        o_tmr_valid = tmr_valid_r;
        o_tmr_idx = tmr_idx_r;
        o_tmr_coil = tmr_coil_r;
        o_tmr_clr = tmr_clr_r;
        o_scan_end = end_r;
        o_running = running_r;
        o_op_err = err_r;
    end

endmodule // lesm_core

// file: testbench/lesm_core_monitor.sv
`timescale 1ns/1ps
module lesm_core_monitor
    import lesm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [3:0] i_op,
    input wire logic i_cond,
    input wire logic [5:0] i_dev,
    input wire logic [7:0] o_pc,
    input wire logic [63:0] o_dev,
    input wire logic o_tmr_valid,
    input wire logic o_tmr_coil,
    input wire logic o_tmr_clr,
    input wire logic o_scan_end,
    input wire logic o_running,
    input wire logic o_op_err
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Last step is excluded: a missing end faults there and clears every device
    wire logic go = o_running && o_pc != 8'hFF;
    a_pc_steps: assert property (go && i_op != LESM_OP_PROG_END |=> o_pc == $past(o_pc) + 8'h01)
        else $error("step skipped");
    a_end_restart: assert property (o_running && i_op == LESM_OP_PROG_END |=> o_pc == 8'h00 && o_scan_end)
        else $error("no restart at step zero");
    a_no_end: assert property (o_running && !go && i_op != LESM_OP_PROG_END |=> o_op_err && o_dev == 64'h0)
        else $error("missing end not refused");
    a_nop_still: assert property (go && i_op == LESM_OP_NOP |=> $stable(o_dev))
        else $error("no-operation changed devices");
    a_out_drop: assert property (o_running && i_op == LESM_OP_OUT && !i_cond |=> !o_dev[$past(i_dev)])
        else $error("output coil stayed on");
    a_set_holds: assert property (go && i_op == LESM_OP_SET && o_dev[i_dev] |=> o_dev[$past(i_dev)])
        else $error("set device dropped");
    a_rise_quiet: assert property (o_running && i_op == LESM_OP_RISE_PULSE && !i_cond |=> !o_dev[$past(i_dev)])
        else $error("rising pulse without edge");
    a_fall_quiet: assert property (o_running && i_op == LESM_OP_FALL_PULSE && i_cond |=> !o_dev[$past(i_dev)])
        else $error("falling pulse without edge");
    a_tmr_clr_off: assert property (o_tmr_valid && o_tmr_clr |-> !o_tmr_coil)
        else $error("cleared timer coil on");
endmodule // lesm_core_monitor

bind lesm_core lesm_core_monitor lesm_core_monitor_i (.i_clk_sys, .i_rst, .i_op, .i_cond, .i_dev, .o_pc,
    .o_dev, .o_tmr_valid, .o_tmr_coil, .o_tmr_clr, .o_scan_end, .o_running, .o_op_err);

// file: testbench/ladder_edge_shift_master_ctrl_test.sv
`timescale 1ns/1ps
module ladder_edge_shift_master_ctrl_test
    import lesm_pkg::*;
;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_run = 1'b1, i_cond = 1'b0;
    logic [3:0] i_op = 4'h0;
    logic [2:0] i_level = 3'h0;
    logic [5:0] i_dev = 6'h00, o_tmr_idx;
    logic [7:0] o_pc;
    logic [63:0] o_dev;
    logic o_tmr_valid, o_tmr_coil, o_tmr_clr, o_scan_end, o_running, o_op_err;
    logic [13:0] prog_m [256];
    logic [1:0] tmr_m [64];
    int n_errors = 0, compares = 0, len;
    lesm_core lesm_core_i (.i_clk_sys, .i_rst, .i_run, .i_op, .i_cond, .i_level, .i_dev, .o_pc, .o_dev,
        .o_tmr_valid, .o_tmr_idx, .o_tmr_coil, .o_tmr_clr, .o_scan_end, .o_running, .o_op_err);
    always #20 i_clk_sys = ~i_clk_sys;
    // Step word is {op, cond, level, dev}; every program keeps step 0 a no-operation,
    // so a step fetched while a new program is being loaded is harmless
    always @(posedge i_clk_sys) begin
        #1;
        {i_op, i_cond, i_level, i_dev} = prog_m[o_pc];
    end
    // Timer commands last one cycle, so keep the last {coil, clear} seen per timer
    always @(posedge i_clk_sys) begin
        if (o_tmr_valid === 1'b1) begin
            tmr_m[o_tmr_idx] <= {o_tmr_coil, o_tmr_clr};
        end
    end
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task scan;
        len = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            len++;
        end while (!(o_scan_end === 1'b1 || o_op_err === 1'b1) && len < 300);
        if (len >= 300) begin
            chk(len, 0);
            give_verdict;
        end
    endtask
    task t_pulse;
        logic [11:0] ex;
        ex = 12'h210;
        prog_m[1] = {LESM_OP_RISE_PULSE, 10'h00A};
        prog_m[2] = {LESM_OP_FALL_PULSE, 10'h00B};
        prog_m[3] = {LESM_OP_PROG_END, 10'h000};
        for (int k = 0; k < 6; k++) begin
            prog_m[1][9] = (k == 2 || k == 3);
            prog_m[2][9] = prog_m[1][9];
            scan;
            if (k > 0) chk(o_dev[11:10], ex[2*k +: 2]);
        end
    endtask
    task t_stop;
        prog_m[1][9] = 1'b1;
        scan;
        chk(o_dev[10], 1'b1);
        i_run = 1'b0;
        scan;
        repeat (3) @(posedge i_clk_sys);
        #1 i_run = 1'b1;
        chk(o_running, 1'b0);
        scan;
        chk(o_dev[10], 1'b0);
    endtask
    task t_shift;
        prog_m[1] = {LESM_OP_BIT_SHIFT, 10'h216};
        prog_m[2] = {LESM_OP_BIT_SHIFT, 10'h215};
        prog_m[3] = {LESM_OP_SET, 10'h214};
        prog_m[4] = {LESM_OP_PROG_END, 10'h000};
        scan;
        chk(o_dev[22:20], 3'h1);
        prog_m[3][9] = 1'b0;
        scan;
        chk(o_dev[22:20], 3'h2);
        scan;
        chk(o_dev[22:20], 3'h4);
        prog_m[1] = {LESM_OP_BIT_SHIFT_EDGE, 10'h017};
        scan;
        chk(o_dev[23:20], 4'h4);
        prog_m[1][9] = 1'b1;
        scan;
        chk(o_dev[23:20], 4'h8);
        scan;
        chk(o_dev[23:20], 4'h8);
    endtask
    task t_range;
        prog_m[1] = {LESM_OP_RANGE_OPEN, 10'h21E};
        prog_m[2] = {LESM_OP_RANGE_OPEN, 10'h25F};
        prog_m[3] = {LESM_OP_OUT, 10'h220};
        prog_m[4] = {LESM_OP_SET, 10'h221};
        prog_m[5] = {LESM_OP_TIMER, 10'h205};
        prog_m[6] = {LESM_OP_TIMER_RET, 10'h206};
        prog_m[7] = {LESM_OP_RANGE_CLOSE, 10'h000};
        prog_m[8] = {LESM_OP_RANGE_OPEN, 10'h223};
        prog_m[9] = {LESM_OP_OUT, 10'h222};
        prog_m[10] = {LESM_OP_RANGE_CLOSE, 10'h000};
        prog_m[11] = {LESM_OP_PROG_END, 10'h000};
        scan;
        chk(o_dev[35:30], 6'h3F);
        chk(tmr_m[5], 2'h2);
        chk(tmr_m[6], 2'h2);
        prog_m[1][9] = 1'b0;
        scan;
        chk(len, 12);
        chk(o_pc, 8'h00);
        chk(o_dev[35:30], 6'h38);
        chk(tmr_m[5], 2'h1);
        chk(tmr_m[6], 2'h0);
    endtask
    task t_noend;
        for (int s = 0; s < 256; s++) prog_m[s] = 14'h0000;
        scan;
        chk(o_op_err, 1'b1);
        chk(o_dev, 64'h0);
        chk(o_running, 1'b0);
    endtask
    initial begin
        for (int s = 0; s < 256; s++) prog_m[s] = 14'h0000;
        repeat (10) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        t_pulse;
        t_stop;
        t_shift;
        t_range;
        t_noend;
        give_verdict;
    end
endmodule // ladder_edge_shift_master_ctrl_test
